// File: inc/arr_pkg.sv
// Constants, types and carriers of the angle readout block
package arr_pkg;

  // ---------------------------------------------------------------
  // Register offsets and frame layout
  // ---------------------------------------------------------------
  localparam logic [6:0] ARR_OFS_WR_PTR = 7'h02;
  localparam logic [6:0] ARR_OFS_ANGLE_SHORT = 7'h20;
  localparam logic [6:0] ARR_OFS_SEC_ANGLE = 7'h24;
  localparam logic [6:0] ARR_OFS_FIELD = 7'h2A;
  localparam logic [6:0] ARR_OFS_ANGLE_FULL = 7'h32;
  localparam int ARR_FRM_WR_BIT = 15;
  localparam int ARR_FRM_ADDR_LSB = 8;
  localparam logic [3:0] ARR_FRM_LAST_BIT = 4'hF;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [7:0] ARR_WR_PTR_RST = 8'h00;
  localparam logic [15:0] ARR_WORD_RST = 16'h0000;
  localparam logic [14:0] ARR_ANGLE_RST = 15'h0000;
  localparam logic [6:0] ARR_ADDR_RST = 7'h20;

  // ---------------------------------------------------------------
  // Timing and parity sense
  // ---------------------------------------------------------------
  localparam int ARR_CLK_PERIOD_NS = 100;
  localparam int ARR_ANG_PERIOD_NS = 1000;
  localparam int ARR_LATENCY_NS = 7000;
  localparam int ARR_SEC_PERIOD_NS = 32000;
  localparam int ARR_FIELD_PERIOD_NS = 128000;
  localparam int ARR_UPD_CYC = ARR_ANG_PERIOD_NS / ARR_CLK_PERIOD_NS;
  localparam int ARR_SEC_CYC = ARR_SEC_PERIOD_NS / ARR_CLK_PERIOD_NS;
  localparam int ARR_FIELD_CYC = ARR_FIELD_PERIOD_NS / ARR_CLK_PERIOD_NS;
  localparam int ARR_LAT_STAGES = ARR_LATENCY_NS / ARR_ANG_PERIOD_NS;
  localparam int ARR_PWM_PERIOD_CYC = 3200;
  localparam logic ARR_PARITY_ODD = 1'b1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic {
    ARR_ST_INIT = 1'b0,
    ARR_ST_RUN = 1'b1
  } arr_state_t;

  typedef struct packed {
    logic zero;
    logic generalErrorFlag;
    logic undervoltageFlag;
    logic parityBit;
    logic [11:0] angle;
  } arr_short_t;

  typedef struct packed {
    logic zero;
    logic [14:0] angle;
  } arr_full_t;

  typedef struct packed {
    arr_short_t angleShort;
    arr_full_t angleFull;
    logic [15:0] field;
    logic [15:0] secAngle;
    logic [15:0] wrPtr;
  } arr_snap_t;

endpackage : arr_pkg

// File: logic/arr_angle_readout.sv
// Angle readout registers with serial link and pulse-width output
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// Periodic tick generator
// -----------------------------------------------------------------
module arr_tick_gen #(
  parameter int PERIOD = 10
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  output logic tick
);
  localparam int W = $clog2(PERIOD);
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);

  logic [W-1:0] cnt_reg;

  generate
    if (PERIOD < 2) begin : g_chk
      $error("arr_tick_gen: PERIOD below 2");
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (srst || !run) begin
      cnt_reg <= '0;
    end else if (cnt_reg == LAST) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tick <= 1'b0;
    end else begin
      tick <= run && (cnt_reg == LAST);
    end
  end
endmodule : arr_tick_gen

module arr_angle_readout #(
  parameter int PWM_PERIOD_CYC = arr_pkg::ARR_PWM_PERIOD_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [14:0] feAngle,
  input wire logic [14:0] secAngle,
  input wire logic [11:0] feField,
  input wire logic generalErrorFlag,
  input wire logic undervoltageFlag,
  input wire logic [14:0] nvmZeroTrim,
  input wire logic nvmTrimEnable,
  input wire logic nvmFilterEnable,
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic pwmOut,
  output logic [14:0] encoderAngle,
  output logic [7:0] extWritePtr
);
  localparam int STAGES = arr_pkg::ARR_LAT_STAGES;
  localparam int PW = $clog2(PWM_PERIOD_CYC) + 1;
  localparam int PWM_LEAD = PWM_PERIOD_CYC / 20;
  localparam int PWM_SPAN = PWM_PERIOD_CYC - 2 * PWM_LEAD;
  localparam logic [PW-1:0] PWM_LAST = PW'(PWM_PERIOD_CYC - 1);
  localparam int UPD_GAP = arr_pkg::ARR_UPD_CYC;
  localparam int SEC_GAP = arr_pkg::ARR_SEC_CYC;

  generate
    if (PWM_PERIOD_CYC < 40 || STAGES < 2) begin : g_chk
      $error("arr_angle_readout: period or latency too short");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Power-up sequence and shadow copy
  // ---------------------------------------------------------------
  arr_pkg::arr_state_t state_reg;
  logic [14:0] shadowTrim_reg;
  logic shadowTrimEn_reg;
  logic shadowFilterEn_reg;
  logic run;

  assign run = (state_reg == arr_pkg::ARR_ST_RUN);

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= arr_pkg::ARR_ST_INIT;
    end else begin
      unique case (state_reg)
        arr_pkg::ARR_ST_INIT: state_reg <= arr_pkg::ARR_ST_RUN;
        arr_pkg::ARR_ST_RUN: state_reg <= arr_pkg::ARR_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      shadowTrim_reg <= arr_pkg::ARR_ANGLE_RST;
      shadowTrimEn_reg <= 1'b0;
      shadowFilterEn_reg <= 1'b0;
    end else if (state_reg == arr_pkg::ARR_ST_INIT) begin
      shadowTrim_reg <= nvmZeroTrim;
      shadowTrimEn_reg <= nvmTrimEnable;
      shadowFilterEn_reg <= nvmFilterEnable;
    end
  end

  // ---------------------------------------------------------------
  // Refresh ticks
  // ---------------------------------------------------------------
  logic updTick;
  logic secTick;
  logic fieldTick;

  arr_tick_gen #(.PERIOD(arr_pkg::ARR_UPD_CYC)) u_upd (
    .clk(clk),
    .srst(srst),
    .run(run),
    .tick(updTick)
  );

  arr_tick_gen #(.PERIOD(arr_pkg::ARR_SEC_CYC)) u_sec (
    .clk(clk),
    .srst(srst),
    .run(run),
    .tick(secTick)
  );

  arr_tick_gen #(.PERIOD(arr_pkg::ARR_FIELD_CYC)) u_field (
    .clk(clk),
    .srst(srst),
    .run(run),
    .tick(fieldTick)
  );

  // ---------------------------------------------------------------
  // Primary path: latency line, trim, views
  // ---------------------------------------------------------------
  logic [14:0] pipe_reg [STAGES];
  logic [14:0] pipeTap;
  logic [14:0] trimAmount;
  logic [14:0] angleTrimmed;
  arr_pkg::arr_short_t shortNext;
  arr_pkg::arr_short_t angleShort_reg;
  arr_pkg::arr_full_t angleFull_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      pipe_reg <= '{default: arr_pkg::ARR_ANGLE_RST};
    end else if (updTick) begin
      pipe_reg[0] <= feAngle;
      for (int i = 1; i < STAGES; i++) begin
        pipe_reg[i] <= pipe_reg[i-1];
      end
    end
  end

  assign pipeTap = shadowFilterEn_reg ? pipe_reg[STAGES-1]
                                      : pipe_reg[STAGES-2];
  assign trimAmount = shadowTrimEn_reg ? shadowTrim_reg
                                       : arr_pkg::ARR_ANGLE_RST;
  assign angleTrimmed = pipeTap - trimAmount;

  always_comb begin
    shortNext.zero = 1'b0;
    shortNext.generalErrorFlag = generalErrorFlag;
    shortNext.undervoltageFlag = undervoltageFlag;
    shortNext.angle = angleTrimmed[14:3];
    shortNext.parityBit = arr_pkg::ARR_PARITY_ODD ^ generalErrorFlag ^
                          undervoltageFlag ^ (^angleTrimmed[14:3]);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      // Reset word keeps the parity sense
      angleShort_reg <= arr_pkg::arr_short_t'({3'b000,
                        arr_pkg::ARR_PARITY_ODD, 12'h000});
      angleFull_reg <= arr_pkg::arr_full_t'(arr_pkg::ARR_WORD_RST);
    end else if (updTick) begin
      angleShort_reg <= shortNext;
      angleFull_reg <= {1'b0, angleTrimmed};
    end
  end

  assign encoderAngle = angleFull_reg.angle;

  // ---------------------------------------------------------------
  // Secondary path and field reading
  // ---------------------------------------------------------------
  logic [15:0] secAngle_reg;
  logic [15:0] field_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      secAngle_reg <= arr_pkg::ARR_WORD_RST;
    end else if (secTick) begin
      secAngle_reg <= {1'b0, secAngle};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      field_reg <= arr_pkg::ARR_WORD_RST;
    end else if (fieldTick) begin
      field_reg <= {4'h0, feField};
    end
  end

  // ---------------------------------------------------------------
  // Pulse-width output
  // ---------------------------------------------------------------
  logic [PW-1:0] pwmCnt_reg;
  logic [PW-1:0] pwmHigh_reg;
  logic [11:0] pwmAngle_reg;
  logic [31:0] pwmProd;
  logic [PW-1:0] pwmHighNext;

  assign pwmProd = 32'(angleShort_reg.angle) * 32'(PWM_SPAN);
  assign pwmHighNext = PW'(PWM_LEAD) + PW'(pwmProd >> 12);

  always_ff @(posedge clk) begin
    if (srst || !run || pwmCnt_reg == PWM_LAST) begin
      pwmCnt_reg <= '0;
    end else begin
      pwmCnt_reg <= pwmCnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pwmHigh_reg <= '0;
      pwmAngle_reg <= 12'h000;
      pwmOut <= 1'b0;
    end else if (!run) begin
      pwmOut <= 1'b0;
    end else if (pwmCnt_reg == '0) begin
      pwmHigh_reg <= pwmHighNext;
      pwmAngle_reg <= angleShort_reg.angle;
      pwmOut <= 1'b1;
    end else begin
      pwmOut <= (pwmCnt_reg < pwmHigh_reg);
    end
  end

  // ---------------------------------------------------------------
  // Snapshot for the serial link, frozen during frames
  // ---------------------------------------------------------------
  logic csSync1_reg;
  logic csSync2_reg;
  arr_pkg::arr_snap_t snap_reg;
  logic wrTogSync1_reg;
  logic wrTogSync2_reg;
  logic wrTogSeen_reg;
  logic wrToggle_reg;
  logic [7:0] wrData_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      csSync1_reg <= 1'b1;
      csSync2_reg <= 1'b1;
      wrTogSync1_reg <= 1'b0;
      wrTogSync2_reg <= 1'b0;
    end else begin
      csSync1_reg <= spiCsN;
      csSync2_reg <= csSync1_reg;
      wrTogSync1_reg <= wrToggle_reg;
      wrTogSync2_reg <= wrTogSync1_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      snap_reg <= '0;
    end else if (csSync2_reg) begin
      snap_reg <= {angleShort_reg, angleFull_reg, field_reg,
                   secAngle_reg, 8'h00, extWritePtr};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      extWritePtr <= arr_pkg::ARR_WR_PTR_RST;
      wrTogSeen_reg <= 1'b0;
    end else if (wrTogSync2_reg != wrTogSeen_reg) begin
      extWritePtr <= wrData_reg;
      wrTogSeen_reg <= wrTogSync2_reg;
    end
  end

  // ---------------------------------------------------------------
  // Serial link logic on the host clock
  // ---------------------------------------------------------------
  logic [3:0] bitCnt_reg;
  logic [14:0] shiftIn_reg;
  logic [15:0] resp_reg;
  logic [6:0] addr_reg;
  logic [15:0] frameWord;
  logic [15:0] readWord;

  assign frameWord = {shiftIn_reg, spiMosi};

  always_comb begin
    case (addr_reg)
      arr_pkg::ARR_OFS_ANGLE_SHORT: readWord = snap_reg.angleShort;
      arr_pkg::ARR_OFS_ANGLE_FULL: readWord = snap_reg.angleFull;
      arr_pkg::ARR_OFS_FIELD: readWord = snap_reg.field;
      arr_pkg::ARR_OFS_SEC_ANGLE: readWord = snap_reg.secAngle;
      arr_pkg::ARR_OFS_WR_PTR: readWord = snap_reg.wrPtr;
      default: readWord = arr_pkg::ARR_WORD_RST;
    endcase
  end

  always_ff @(posedge spiSclk or posedge spiCsN) begin
    if (spiCsN) begin
      bitCnt_reg <= 4'h0;
      shiftIn_reg <= 15'h0000;
      resp_reg <= arr_pkg::ARR_WORD_RST;
    end else begin
      bitCnt_reg <= bitCnt_reg + 1'b1;
      shiftIn_reg <= frameWord[14:0];
      if (bitCnt_reg == 4'h0) begin
        resp_reg <= readWord;
      end else begin
        resp_reg <= {resp_reg[14:0], 1'b0};
      end
    end
  end

  always_ff @(negedge spiSclk or posedge spiCsN) begin
    if (spiCsN) begin
      spiMiso <= 1'b0;
    end else begin
      spiMiso <= resp_reg[14];
    end
  end

  always_ff @(posedge spiSclk or posedge srst) begin
    if (srst) begin
      addr_reg <= arr_pkg::ARR_ADDR_RST;
      wrToggle_reg <= 1'b0;
      wrData_reg <= arr_pkg::ARR_WR_PTR_RST;
    end else if (!spiCsN && bitCnt_reg == arr_pkg::ARR_FRM_LAST_BIT) begin
      addr_reg <= frameWord[arr_pkg::ARR_FRM_WR_BIT-1:
                            arr_pkg::ARR_FRM_ADDR_LSB];
      if (frameWord[arr_pkg::ARR_FRM_WR_BIT] &&
          frameWord[arr_pkg::ARR_FRM_WR_BIT-1:arr_pkg::ARR_FRM_ADDR_LSB] ==
          arr_pkg::ARR_OFS_WR_PTR) begin
        wrData_reg <= frameWord[7:0];
        wrToggle_reg <= ~wrToggle_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_UPD_SPACING: assert property (@(posedge clk) disable iff (srst)
    updTick |-> ##[UPD_GAP:UPD_GAP] updTick)
    else $error("angle update spacing wrong");

  AST_SHORT_VIEW: assert property (@(posedge clk) disable iff (srst)
    !angleShort_reg.zero &&
    angleShort_reg.angle == angleFull_reg.angle[14:3])
    else $error("short view not aligned with full view");

  AST_FULL_TOP: assert property (@(posedge clk) disable iff (srst)
    updTick |=> !angleFull_reg.zero)
    else $error("full view top bit set");

  AST_PARITY: assert property (@(posedge clk) disable iff (srst)
    (^angleShort_reg) == arr_pkg::ARR_PARITY_ODD)
    else $error("parity sense wrong");

  AST_TRIM: assert property (@(posedge clk) disable iff (srst)
    updTick |=> angleFull_reg.angle ==
      $past(pipeTap) - $past(trimAmount))
    else $error("trimmed angle wrong");

  AST_SEC_RATE: assert property (@(posedge clk) disable iff (srst)
    secTick |-> ##[SEC_GAP:SEC_GAP] secTick)
    else $error("secondary refresh spacing wrong");

  AST_FIELD_HOLD: assert property (@(posedge clk) disable iff (srst)
    !fieldTick |=> $stable(field_reg))
    else $error("field reading changed off its tick");

  AST_PWM_LATCH: assert property (@(posedge clk) disable iff (srst)
    run && pwmCnt_reg == '0 |=> pwmOut &&
      pwmAngle_reg == $past(angleShort_reg.angle))
    else $error("pulse period did not latch angle");

  AST_SNAP_FROZEN: assert property (@(posedge clk) disable iff (srst)
    !csSync2_reg ##1 !csSync2_reg |-> $stable(snap_reg))
    else $error("snapshot moved during frame");

  AST_INIT_COPY: assert property (@(posedge clk) disable iff (srst)
    state_reg == arr_pkg::ARR_ST_INIT |=>
      shadowTrim_reg == $past(nvmZeroTrim) && run)
    else $error("shadow not recopied at init");

  AST_READ_SELECT: assert property (@(posedge spiSclk) disable iff (spiCsN)
    bitCnt_reg == 4'h0 && addr_reg == arr_pkg::ARR_OFS_ANGLE_FULL
      |=> resp_reg == snap_reg.angleFull)
    else $error("full view not selected");

  COV_UPDATE: cover property (@(posedge clk) disable iff (srst)
    updTick ##1 angleShort_reg.generalErrorFlag);
  COV_PTR_WRITE: cover property (@(posedge clk) disable iff (srst)
    wrTogSync2_reg != wrTogSeen_reg);
  COV_PWM_START: cover property (@(posedge clk) disable iff (srst)
    run && pwmCnt_reg == '0);
  COV_FRAME_END: cover property (@(posedge spiSclk) disable iff (spiCsN)
    bitCnt_reg == arr_pkg::ARR_FRM_LAST_BIT);

endmodule : arr_angle_readout

`default_nettype wire

// File: logic/arr_addr_note.sv
// Reserved: the link address field is decoded in the readout block
`default_nettype none
`default_nettype wire

// File: tb/arr_spi_host.sv
// Host-side serial link model for the angle readout block
`timescale 1ns/1ps
`default_nettype none
module arr_spi_host (
  output logic spiSclk,
  output logic spiCsN,
  output logic spiMosi,
  input wire logic spiMiso
);
  localparam realtime HALF = 62.5;

  initial begin
    spiSclk = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
  end

  // ---------------------------------------------------------------
  // One 16-bit frame, clock idle low, stands still between frames
  // ---------------------------------------------------------------
  task automatic frame(input logic [15:0] txWord,
                       output logic [15:0] rxWord);
    int k;
    spiCsN = 1'b0;
    #400;
    for (k = 15; k >= 0; k--) begin
      spiMosi = txWord[k];
      #HALF spiSclk = 1'b1;
      rxWord[k] = spiMiso;
      #HALF spiSclk = 1'b0;
    end
    // Released data line shows the inverse of its last bit
    spiMosi = ~txWord[0];
    #100 spiCsN = 1'b1;
    #500;
  endtask : frame
endmodule : arr_spi_host
`default_nettype wire

// File: tb/arr_angle_readout_tb.sv
// Self-checking bench for the angle readout block
`timescale 1ns/1ps
`default_nettype none
module arr_angle_readout_tb;
  localparam int PWM = 200;
  localparam int U = arr_pkg::ARR_UPD_CYC;
  localparam int ST = arr_pkg::ARR_LAT_STAGES;
  logic clk, srst, trimEn, filtEn, err, uv;
  logic [14:0] feAngle, secAngle, trim, encoderAngle;
  logic [11:0] feField;
  logic [7:0] extWritePtr;
  logic spiSclk, spiCsN, spiMosi, spiMiso, pwmOut;
  int failures, checkCount, seedVal;

  arr_angle_readout #(.PWM_PERIOD_CYC(PWM)) i_arr_angle_readout (
    .clk(clk), .srst(srst), .feAngle(feAngle), .secAngle(secAngle),
    .feField(feField), .generalErrorFlag(err), .undervoltageFlag(uv),
    .nvmZeroTrim(trim), .nvmTrimEnable(trimEn), .nvmFilterEnable(filtEn),
    .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi),
    .spiMiso(spiMiso), .pwmOut(pwmOut), .encoderAngle(encoderAngle),
    .extWritePtr(extWritePtr));

  arr_spi_host i_arr_spi_host (.spiSclk(spiSclk), .spiCsN(spiCsN),
    .spiMosi(spiMosi), .spiMiso(spiMiso));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Expectations and helpers
  // ---------------------------------------------------------------
  function automatic logic [14:0] fullOf(input logic [14:0] a);
    return a - (trimEn ? trim : 15'h0000);
  endfunction : fullOf

  function automatic logic [15:0] shortOf(input logic [14:0] f,
                                          input logic e, input logic u);
    logic [15:0] w;
    w = {1'b0, e, u, 1'b0, f[14:3]};
    w[12] = ~(^w);
    return w;
  endfunction : shortOf

  task automatic give_verdict();
    if (failures == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic doReset(input logic f, input logic t);
    @(posedge clk);
    srst <= 1'b1;
    filtEn <= f;
    trimEn <= t;
    trim <= 15'($urandom);
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    // link and angle trusted only after settling
    repeat (120) @(posedge clk);
  endtask : doReset

  task automatic readReg(input logic [6:0] addr, output logic [15:0] val);
    logic [15:0] junk;
    i_arr_spi_host.frame({1'b0, addr, 8'h00}, junk);
    i_arr_spi_host.frame(16'h0000, val);
  endtask : readReg

  task automatic waitPwm(input logic lvl, output int n);
    n = 0;
    while (pwmOut !== lvl) begin
      @(posedge clk);
      n++;
      if (n > 2 * PWM) begin
        failures++;
        $display("BAD %0t pulse output stuck", $time);
        give_verdict();
      end
    end
  endtask : waitPwm

  task automatic pwmCheck(input logic [11:0] a);
    int n, hi, lo;
    waitPwm(1'b0, n);
    waitPwm(1'b1, n);
    waitPwm(1'b0, hi);
    waitPwm(1'b1, lo);
    check(16'(hi), 16'(PWM / 20 + ((a * (PWM - 2 * (PWM / 20))) >> 12)));
    check(16'(hi + lo), 16'(PWM));
  endtask : pwmCheck

  // Ramp input to find update phase, then step and time the output
  task automatic measureLat(output int lat, output int gap);
    logic [14:0] prev, v;
    int k, c1;
    c1 = -1;
    gap = 0;
    v = 15'h0000;
    // Fill the latency line so every update shows a new value
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      feAngle <= feAngle + 15'h0001;
    end
    prev = encoderAngle;
    for (k = 0; k < 40 && gap == 0; k++) begin
      @(posedge clk);
      if (encoderAngle !== prev) begin
        if (c1 >= 0) gap = k - c1;
        c1 = k;
        prev = encoderAngle;
      end
      v = feAngle + 15'h4000;
      if (gap == 0) feAngle <= feAngle + 15'h0001;
      else feAngle <= v;
    end
    for (lat = 0; lat < 200 && encoderAngle !== fullOf(v); lat++) begin
      @(posedge clk);
    end
  endtask : measureLat

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int i, lat0, lat1, gap;
    logic [14:0] a, f;
    logic [15:0] w;
    logic [7:0] d;
    seedVal = $urandom(32'h1829);
    srst = 1'b1;
    filtEn = 1'b1;
    trimEn = 1'b1;
    trim = 15'h0000;
    feAngle = 15'h0000;
    secAngle = 15'h0000;
    feField = 12'h000;
    err = 1'b0;
    uv = 1'b0;
    failures = 0;
    checkCount = 0;
    doReset(1'b1, 1'b1);
    check({8'h00, extWritePtr}, 16'h0000);
    check({15'h0000, spiMiso}, 16'h0000);
    // Zero and all-ones results first, then random angles
    for (i = 0; i < 8; i++) begin
      a = (i == 0) ? trim : (i == 1) ? trim - 15'h0001 : 15'($urandom);
      @(posedge clk);
      feAngle <= a;
      err <= i[0];
      uv <= i[1];
      repeat (100) @(posedge clk);
      f = fullOf(a);
      readReg(arr_pkg::ARR_OFS_ANGLE_FULL, w);
      check(w, {1'b0, f});
      check({1'b0, encoderAngle}, {1'b0, f});
      readReg(arr_pkg::ARR_OFS_ANGLE_SHORT, w);
      check(w, shortOf(f, i[0], i[1]));
      pwmCheck(f[14:3]);
    end
    @(posedge clk);
    feField <= 12'($urandom);
    secAngle <= 15'($urandom);
    repeat (1400) @(posedge clk);
    readReg(arr_pkg::ARR_OFS_FIELD, w);
    check(w, {4'h0, feField});
    readReg(arr_pkg::ARR_OFS_SEC_ANGLE, w);
    check(w, {1'b0, secAngle});
    readReg(7'h10, w);
    check(w, 16'h0000);
    d = 8'($urandom);
    i_arr_spi_host.frame({1'b1, arr_pkg::ARR_OFS_WR_PTR, d}, w);
    repeat (5) @(posedge clk);
    check({8'h00, extWritePtr}, {8'h00, d});
    measureLat(lat1, gap);
    check(16'(gap), 16'(U));
    check(16'(lat1 >= (ST - 1) * U && lat1 <= (ST + 1) * U), 16'h0001);
    check(16'(6 * lat1 >= 360 && 6 * lat1 <= 480), 16'h0001);
    doReset(1'b0, 1'b0);
    check({8'h00, extWritePtr}, 16'h0000);
    readReg(arr_pkg::ARR_OFS_ANGLE_FULL, w);
    check(w, {1'b0, feAngle});
    measureLat(lat0, gap);
    check(16'(gap), 16'(U));
    check(16'(lat1 - lat0), 16'(U));
    give_verdict();
  end
endmodule : arr_angle_readout_tb
`default_nettype wire
